// ===== include/bsp_defs.svh
// Constants of the burst memory pin controller
`ifndef BSP_DEFS_SVH
`define BSP_DEFS_SVH

`define BSP_ADDR_W      20
`define BSP_LANES       4
`define BSP_LANE_W      8
`define BSP_BURST_W     2
`define BSP_SYNC_RST    2'h0
`define BSP_ORDER_RST   2'h3
`define BSP_BURST_INC   2'h1

`endif

// ===== include/bsp_pkg.sv
// Types shared by the burst memory pin controller
package bsp_pkg;
	typedef enum logic [1:0] {
		BSP_CYC_IDLE,
		BSP_CYC_READ,
		BSP_CYC_WRITE
	} bsp_cyc_e;
endpackage

// ===== include/bsp_mem_if.sv
// Carrier between the controller and its storage array
`timescale 1ns/1ps
`default_nettype none
interface bsp_mem_if #(
	parameter int AW     = 20,
	parameter int LANES  = 4,
	parameter int LANE_W = 8
);
	logic [LANES-1:0]        we;
	logic [AW-1:0]           waddr;
	logic [LANES*LANE_W-1:0] wdata;
	logic [AW-1:0]           raddr;
	logic [LANES*LANE_W-1:0] rdata;

	modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ===== rtl/bsp_mem.sv
// Storage array with per-lane write and registered read
`timescale 1ns/1ps
`default_nettype none
module bsp_mem #(
	parameter int AW     = 20,
	parameter int LANES  = 4,
	parameter int LANE_W = 8
) (
	input  wire logic CLK_I,
	bsp_mem_if.store  port
);
	import bsp_pkg::*;

	logic [LANES*LANE_W-1:0] store [0:(2**AW)-1];
	logic [LANES*LANE_W-1:0] rd;

	// Read registered so data leave one edge after the address stage
	always_ff @(posedge CLK_I) begin
		for (int i = 0; i < LANES; i++) begin
			if (port.we[i]) begin
				store[port.waddr][i*LANE_W +: LANE_W] <= port.wdata[i*LANE_W +: LANE_W];
			end
		end
		rd <= store[port.raddr];
	end

	assign port.rdata = rd;
endmodule
`default_nettype wire

// ===== rtl/bsp_sram.sv
// Pin-level control of a pipelined burst synchronous memory
// Operation
// - Clocked inputs sampled; enable, sleep, order asynchronous
// - Address captured only when selected with strobe
// - Data driven only while selected and enabled
// - Master select blocks processor strobe, not controller
// - Secondary selects polarity; sampled with valid strobe
// - Strobe loads address or enters standby
// - Advance low continues burst read or write
// - All-lanes write low writes every bit
// - Gate and lane enable low make write
// - Output enable drives pins only during read
// - Order select high interleaved, low linear
// - Interleaved burst: start xor 1, 2, 3
// - Linear burst: low bits plus one, wrapping
// - Sleep request holds low power, deselected
// - Asleep: inputs ignored, outputs off
// - Read data appear one edge after address
// - Advance ignored on processor strobe edge
// - Controller start needs processor strobe high or blocked
// - Burst steps only with both strobes high
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"
module bsp_sram #(
	parameter int AW     = `BSP_ADDR_W,
	parameter int LANES  = `BSP_LANES,
	parameter int LANE_W = `BSP_LANE_W
) (
	input  wire logic                    CLK_I,
	input  wire logic                    SYS_RST_I,
	input  wire logic [AW-1:0]           ADDR_I,
	input  wire logic [LANES*LANE_W-1:0] DQ_I,
	output logic      [LANES*LANE_W-1:0] DQ_O,
	output logic                         DQ_OE_O,
	input  wire logic                    MASTER_SELECT_N_I,
	input  wire logic                    SELECT_HIGH_ACTIVE_I,
	input  wire logic                    SELECT_LOW_ACTIVE_N_I,
	input  wire logic                    PROC_ADDR_STROBE_N_I,
	input  wire logic                    CTRL_ADDR_STROBE_N_I,
	input  wire logic                    BURST_ADVANCE_N_I,
	input  wire logic                    ALL_LANES_WRITE_N_I,
	input  wire logic                    LANE_WRITE_GATE_N_I,
	input  wire logic [LANES-1:0]        LANE_WRITE_N_I,
	input  wire logic                    OUTPUT_ENABLE_N_I,
	input  wire logic                    BURST_ORDER_SEL_I,
	input  wire logic                    SLEEP_REQUEST_I,
	output logic                         SLEEP_O
);
	import bsp_pkg::*;

	typedef struct packed {
		logic [1:0]              oe_sync;
		logic [1:0]              slp_sync;
		logic [1:0]              ord_sync;
		logic                    active;
		bsp_cyc_e                cyc;
		logic [AW-1:0]           addr;
		logic [`BSP_BURST_W-1:0] base;
		logic [`BSP_BURST_W-1:0] bcnt;
		logic                    rd_pend;
		logic                    dq_oe;
	} bsp_state_s;

	bsp_state_s st;
	bsp_state_s next_st;

	logic             sleeping;
	logic             proc_ok;
	logic             strobe;
	logic             all_sel;
	logic             step;
	logic [LANES-1:0] lane_mask;

	bsp_mem_if #(.AW(AW), .LANES(LANES), .LANE_W(LANE_W)) mif ();

	bsp_mem #(.AW(AW), .LANES(LANES), .LANE_W(LANE_W)) u_mem (
		.CLK_I (CLK_I),
		.port  (mif.store)
	);

	// Lanes written this edge; empty mask means a read cycle
	function automatic logic [LANES-1:0] lane_mask_f(
		input logic             all_n,
		input logic             gate_n,
		input logic [LANES-1:0] lane_n
	);
		logic [LANES-1:0] m;
		m = '0;
		if (!all_n) begin
			m = '1;
		end else if (!gate_n) begin
			m = ~lane_n;
		end
		return m;
	endfunction

	// Next low address bits; count is steps taken so far
	// interleaved start xor count plus one
	function automatic logic [`BSP_BURST_W-1:0] burst_next_f(
		input logic [`BSP_BURST_W-1:0] cur,
		input logic [`BSP_BURST_W-1:0] cnt,
		input logic                    ilv
	);
		logic [`BSP_BURST_W-1:0] inc;
		inc = cnt + `BSP_BURST_INC;
		return ilv ? (cur ^ cnt ^ inc) : (cur + `BSP_BURST_INC);
	endfunction

	always_comb begin
		sleeping  = st.slp_sync[1];
		proc_ok   = !PROC_ADDR_STROBE_N_I && !MASTER_SELECT_N_I;
		// controller start needs processor strobe high or blocked
		strobe    = proc_ok || !CTRL_ADDR_STROBE_N_I;
		all_sel   = !MASTER_SELECT_N_I && SELECT_HIGH_ACTIVE_I && !SELECT_LOW_ACTIVE_N_I;
		// step only with both strobes high
		step      = PROC_ADDR_STROBE_N_I && CTRL_ADDR_STROBE_N_I && !BURST_ADVANCE_N_I;
		// all-lanes write wins over gate and lanes
		lane_mask = lane_mask_f(ALL_LANES_WRITE_N_I, LANE_WRITE_GATE_N_I, LANE_WRITE_N_I);

		next_st = st;
		// asynchronous pins pass two flops first
		next_st.oe_sync  = {st.oe_sync[0], !OUTPUT_ENABLE_N_I};
		next_st.slp_sync = {st.slp_sync[0], SLEEP_REQUEST_I};
		next_st.ord_sync = {st.ord_sync[0], BURST_ORDER_SEL_I};

		if (sleeping) begin
			next_st.active = 1'b0;
			next_st.cyc    = BSP_CYC_IDLE;
		end else if (strobe) begin
			if (all_sel) begin
				next_st.active = 1'b1;
				next_st.addr   = ADDR_I;
				next_st.base   = ADDR_I[`BSP_BURST_W-1:0];
				next_st.bcnt   = '0;
				// processor start is a read, advance unused
				next_st.cyc    = (!proc_ok && |lane_mask) ? BSP_CYC_WRITE : BSP_CYC_READ;
			end else begin
				next_st.active = 1'b0;
				next_st.cyc    = BSP_CYC_IDLE;
			end
		end else if (st.active) begin
			if (step) begin
				// upper bits kept, group never left
				next_st.addr[`BSP_BURST_W-1:0] =
					burst_next_f(st.addr[`BSP_BURST_W-1:0], st.bcnt, st.ord_sync[1]);
				next_st.bcnt = st.bcnt + `BSP_BURST_INC;
			end
			// write only with a lane selected
			next_st.cyc = |lane_mask ? BSP_CYC_WRITE : BSP_CYC_READ;
		end else begin
			next_st.cyc = BSP_CYC_IDLE;
		end

		next_st.rd_pend = (next_st.cyc == BSP_CYC_READ);
		// pins driven for a selected read with enable
		// enable acts only on a read cycle
		next_st.dq_oe   = st.rd_pend && st.oe_sync[1] && !sleeping;

		// only the enabled lanes are written
		mif.we    = (next_st.cyc == BSP_CYC_WRITE) ? lane_mask : '0;
		mif.waddr = next_st.addr;
		mif.wdata = DQ_I;
		// array read from the registered address
		mif.raddr = st.addr;
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			st          <= '0;
			st.oe_sync  <= `BSP_SYNC_RST;
			st.slp_sync <= `BSP_SYNC_RST;
			// order defaults to interleaved like the pull-up
			st.ord_sync <= `BSP_ORDER_RST;
		end else begin
			st <= next_st;
		end
	end

	assign DQ_O    = mif.rdata;
	assign DQ_OE_O = st.dq_oe;
	assign SLEEP_O = st.slp_sync[1];

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence s_load;
		!sleeping && strobe && all_sel;
	endsequence

	sequence s_step;
		!sleeping && !strobe && st.active && step;
	endsequence

	chk_addr_load: assert property (s_load |=> st.addr == $past(ADDR_I))
		else $error("address not captured on selected strobe");
	chk_standby_entry: assert property (!sleeping && strobe && !all_sel |=> !st.active)
		else $error("unselected strobe did not deselect");
	chk_blocked_proc: assert property (
		MASTER_SELECT_N_I && !PROC_ADDR_STROBE_N_I && CTRL_ADDR_STROBE_N_I
		|=> st.addr == $past(st.addr))
		else $error("blocked processor strobe moved the address");
	chk_read_pipe: assert property (s_load ##1 1'b1 |-> mif.raddr == $past(ADDR_I))
		else $error("read address stage mismatch");
	chk_drive_cause: assert property (
		DQ_OE_O |-> $past(st.rd_pend) && $past(st.oe_sync[1]) && !$past(sleeping))
		else $error("pins driven outside an enabled read");
	chk_linear_step: assert property (
		s_step and !st.ord_sync[1]
		|=> st.addr[1:0] == $past(st.addr[1:0]) + 2'h1)
		else $error("linear burst step wrong");
	chk_ilv_order: assert property (
		s_step and st.ord_sync[1] and $stable(st.ord_sync[1])
		|=> st.addr[1:0] == (st.base ^ st.bcnt))
		else $error("interleaved burst step wrong");
	chk_upper_hold: assert property (s_step |=> st.addr[AW-1:2] == $past(st.addr[AW-1:2]))
		else $error("burst changed upper address bits");
	chk_all_lanes: assert property (
		!sleeping && !ALL_LANES_WRITE_N_I
		&& ((st.active && !strobe) || (strobe && all_sel && !proc_ok))
		|-> mif.we == '1)
		else $error("all-lanes write missed a lane");
	chk_sleep_quiet: assert property (sleeping |-> mif.we == '0 ##1 !DQ_OE_O && !st.active)
		else $error("activity while asleep");
endmodule
`default_nettype wire

// ===== sim/bsp_master.sv
// Bus master model that drives the memory pins
`timescale 1ns/1ps
`default_nettype none
module bsp_master #(
	parameter int AW = 8
) (
	input  wire logic          clk_i,
	output var  logic [AW-1:0] addr_o,
	output var  logic [31:0]   dq_o,
	output var  logic [2:0]    sel_o,
	output var  logic [1:0]    strobe_n_o,
	output var  logic          adv_n_o,
	output var  logic          all_n_o,
	output var  logic          gate_n_o,
	output var  logic [3:0]    lane_n_o,
	output var  logic          oe_n_o,
	output var  logic          order_o,
	output var  logic          sleep_o
);
	initial begin
		{addr_o, dq_o, sel_o, lane_n_o} = {{AW{1'b0}}, 32'h0, 3'h5, 4'hF};
		{strobe_n_o, adv_n_o, all_n_o, gate_n_o, oe_n_o, order_o, sleep_o} = 8'hFE;
	end

	task automatic cyc(input logic [AW-1:0] a, input logic ctl, input logic [2:0] sel,
			input logic wall, input logic [3:0] ln, input logic [31:0] d, input logic burst_advance_n);
		@(negedge clk_i);
		// output enable off before a write
		oe_n_o = !(wall && ln == 4'hF);
		// processor strobe high with controller strobe
		{addr_o, sel_o, strobe_n_o} = {a, sel, ctl, !ctl};
		{all_n_o, gate_n_o, lane_n_o, dq_o} = {wall, ln == 4'hF, ln, d};
		@(negedge clk_i);
		{strobe_n_o, adv_n_o, all_n_o, gate_n_o, lane_n_o} = {2'h3, burst_advance_n, 2'h3, 4'hF};
		// Released bus must not keep the old value
		dq_o = ~dq_o;
	endtask

	task automatic mode(input logic ord, input logic slp, input logic burst_advance_n);
		@(negedge clk_i);
		{order_o, sleep_o, adv_n_o} = {ord, slp, burst_advance_n};
	endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the burst memory pin controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr;
	logic [31:0] dq_m, dq_q;
	logic [2:0]  sel;
	logic [1:0]  stb_n;
	logic [3:0]  lane_n;
	logic        adv_n, all_n, gate_n, oe_n, order, sleep, dq_oe, asleep;
	int          error_cnt = 0;
	int          total_checks = 0;

	always #2 clk = ~clk;

	bsp_master #(.AW(8)) m (.clk_i(clk), .addr_o(addr), .dq_o(dq_m), .sel_o(sel),
		.strobe_n_o(stb_n), .adv_n_o(adv_n), .all_n_o(all_n), .gate_n_o(gate_n),
		.lane_n_o(lane_n), .oe_n_o(oe_n), .order_o(order), .sleep_o(sleep));

	bsp_sram #(.AW(8)) uut (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .DQ_I(dq_m),
		.DQ_O(dq_q), .DQ_OE_O(dq_oe), .MASTER_SELECT_N_I(sel[2]),
		.SELECT_HIGH_ACTIVE_I(sel[1]), .SELECT_LOW_ACTIVE_N_I(sel[0]),
		.PROC_ADDR_STROBE_N_I(stb_n[1]), .CTRL_ADDR_STROBE_N_I(stb_n[0]),
		.BURST_ADVANCE_N_I(adv_n), .ALL_LANES_WRITE_N_I(all_n),
		.LANE_WRITE_GATE_N_I(gate_n), .LANE_WRITE_N_I(lane_n),
		.OUTPUT_ENABLE_N_I(oe_n), .BURST_ORDER_SEL_I(order),
		.SLEEP_REQUEST_I(sleep), .SLEEP_O(asleep));

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		m.cyc(a, 1'b0, 3'h2, 1'b1, 4'hF, 32'h0, 1'b1);
		@(negedge clk);
		`CHK(dq_q, e)
		@(negedge clk);
		`CHK(dq_oe, 1'b1)
	endtask

	task automatic t_write();
		m.cyc(8'h10, 1'b1, 3'h2, 1'b0, 4'h5, 32'hA5A5_5A5A, 1'b1);
		rd(8'h10, 32'hA5A5_5A5A);
		$display("test write done");
	endtask

	task automatic t_lanes();
		m.cyc(8'h20, 1'b1, 3'h2, 1'b0, 4'hF, 32'h1111_1111, 1'b1);
		m.cyc(8'h20, 1'b1, 3'h2, 1'b1, 4'hE, 32'h2222_2222, 1'b1);
		m.cyc(8'h20, 1'b1, 3'h2, 1'b1, 4'h3, 32'h3333_3333, 1'b1);
		rd(8'h20, 32'h3333_1122);
		$display("test lanes done");
	endtask

	task automatic t_burst();
		logic [1:0] idx;
		for (int i = 0; i < 4; i++)
			m.cyc(8'h30 + 8'(i), 1'b1, 3'h2, 1'b0, 4'hF, 32'hC0DE_0000 + 32'(i), 1'b1);
		for (int o = 0; o < 2; o++) begin
			m.mode(1'(1 - o), 1'b0, 1'b1);
			repeat (3) @(negedge clk);
			m.cyc(8'h31, 1'b0, 3'h2, 1'b1, 4'hF, 32'h0, 1'b0);
			for (int k = 0; k < 4; k++) begin
				idx = (o == 0) ? 2'h1 ^ 2'(k) : 2'h1 + 2'(k);
				@(negedge clk);
				`CHK(dq_q, 32'hC0DE_0000 + 32'(idx))
			end
			m.mode(1'(1 - o), 1'b0, 1'b1);
		end
		$display("test burst done");
	endtask

	task automatic t_refuse();
		rd(8'h10, 32'hA5A5_5A5A);
		m.cyc(8'h20, 1'b0, 3'h6, 1'b1, 4'hF, 32'h0, 1'b1);
		repeat (2) @(negedge clk);
		`CHK(dq_q, 32'hA5A5_5A5A)
		m.cyc(8'h20, 1'b1, 3'h6, 1'b1, 4'hF, 32'h0, 1'b1);
		repeat (2) @(negedge clk);
		`CHK(dq_oe, 1'b0)
		m.cyc(8'h10, 1'b0, 3'h2, 1'b0, 4'hF, 32'h0, 1'b1);
		m.cyc(8'h10, 1'b1, 3'h0, 1'b1, 4'hF, 32'h0, 1'b1);
		repeat (2) @(negedge clk);
		`CHK(dq_oe, 1'b0)
		rd(8'h10, 32'hA5A5_5A5A);
		$display("test refuse done");
	endtask

	task automatic t_sleep();
		m.mode(1'b1, 1'b1, 1'b1);
		repeat (4) @(negedge clk);
		`CHK(asleep, 1'b1)
		`CHK(dq_oe, 1'b0)
		m.cyc(8'h10, 1'b1, 3'h2, 1'b0, 4'hF, 32'h0BAD_0BAD, 1'b1);
		m.mode(1'b1, 1'b0, 1'b1);
		repeat (4) @(negedge clk);
		`CHK(asleep, 1'b0)
		rd(8'h10, 32'hA5A5_5A5A);
		$display("test sleep done");
	endtask

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_write();
		t_lanes();
		t_burst();
		t_refuse();
		t_sleep();
		stop_test();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#20000;
		error_cnt++;
		stop_test();
	end
endmodule
`default_nettype wire
